// File: hsst_consts.svh
/*
 * Named constants for the high-side switch timer control block.
 * Assumes a 50 MHz system clock and a 32-bit classic Wishbone bus.
 */
`ifndef HSST_CONSTS_SVH
`define HSST_CONSTS_SVH

`define HSST_IDX_TMR     8'h0d
`define HSST_IDX_SUP     8'h10
`define HSST_IDX_SWLO    8'h14
`define HSST_IDX_SWHI    8'h15

`define HSST_RST_VAL     8'h00
`define HSST_TMR_MASK    8'h77
`define HSST_SUP_MASK    8'h70
`define HSST_SW_MASK     8'h77

`define HSST_BIT_OV_DIS  6
`define HSST_BIT_UV_DIS  5
`define HSST_BIT_REC     4
`define HSST_HI_LSB      4
`define HSST_LO_LSB      0

`define HSST_ON_OFF      3'h0
`define HSST_ON_HIGH     3'h6
`define HSST_CODE_RSV    3'h7

`define HSST_SEL_OFF     3'h0
`define HSST_SEL_ON      3'h1
`define HSST_SEL_TA      3'h2
`define HSST_SEL_TB      3'h3
`define HSST_SEL_DA      3'h4
`define HSST_SEL_DB      3'h5

`define HSST_FLT_OV      9
`define HSST_FLT_UV      8
`define HSST_FLT_OT_LSB  4
`define HSST_FLT_OC_LSB  0

`define HSST_CLK_NS      20
`define HSST_TICK_NS     10000
`define HSST_TICK_CYC    (`HSST_TICK_NS / `HSST_CLK_NS)
`define HSST_NS_PER_US   1000
`define HSST_NS_PER_MS   1000000

`define HSST_ON_US_1     100
`define HSST_ON_US_2     300
`define HSST_ON_US_3     1000
`define HSST_ON_US_4     10000
`define HSST_ON_US_5     20000

`define HSST_PER_MS_0    10
`define HSST_PER_MS_1    20
`define HSST_PER_MS_2    50
`define HSST_PER_MS_3    100
`define HSST_PER_MS_4    200
`define HSST_PER_MS_5    1000
`define HSST_PER_MS_6    2000

`endif

// File: hsst_pkg.sv
/*
 * Types shared by the switch timer control files.
 * Assumes hsst_consts.svh supplies all numeric constants.
 */
package hsst_pkg;

    typedef struct packed {
        logic [9:0] s1;
        logic [9:0] s2;
        logic [9:0] s3;
        logic [9:0] flt;
        logic [7:0] tmr;
        logic [7:0] sup;
        logic [7:0] sw_lo;
        logic [7:0] sw_hi;
        logic [3:0] out;
        logic [7:0] rdat;
        logic       ack;
    } hsst_state_type;

    typedef struct packed {
        logic [8:0]  div;
        logic        tick;
        logic [17:0] cnt;
        logic [2:0]  on_l;
        logic [2:0]  per_l;
        logic        out;
    } hsst_tmr_state_type;

endpackage

// File: hsst_cyc_timer.sv
/*
 * Cyclic pulse timer: high for the on-time at the start of every period.
 * Assumes codes come from registers on the same clock; reset is synchronised.
 */
`timescale 1ns/100ps
`default_nettype none
`include "hsst_consts.svh"

module hsst_cyc_timer
(
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic [2:0] on_code,
    input  wire logic [2:0] per_code,
    output logic            pulse_out
);

    hsst_pkg::hsst_tmr_state_type st_r;
    hsst_pkg::hsst_tmr_state_type st_nxt;

    logic        running;
    logic [17:0] on_ticks;
    logic [17:0] per_ticks;

    function automatic logic [17:0] on_len(input logic [2:0] c);
        int us;
        case (c)
            3'h1:    us = `HSST_ON_US_1;
            3'h2:    us = `HSST_ON_US_2;
            3'h3:    us = `HSST_ON_US_3;
            3'h4:    us = `HSST_ON_US_4;
            3'h5:    us = `HSST_ON_US_5;
            default: us = 0;
        endcase
        on_len = 18'(us * `HSST_NS_PER_US / `HSST_TICK_NS);
    endfunction

    function automatic logic [17:0] per_len(input logic [2:0] c);
        int ms;
        case (c)
            3'h0:    ms = `HSST_PER_MS_0;
            3'h1:    ms = `HSST_PER_MS_1;
            3'h2:    ms = `HSST_PER_MS_2;
            3'h3:    ms = `HSST_PER_MS_3;
            3'h4:    ms = `HSST_PER_MS_4;
            3'h5:    ms = `HSST_PER_MS_5;
            3'h6:    ms = `HSST_PER_MS_6;
            default: ms = 0;
        endcase
        per_len = 18'(ms * (`HSST_NS_PER_MS / `HSST_TICK_NS));
    endfunction

    ////////////////////////////////////////////////////////////////////////////

    always_comb
    begin
        st_nxt = st_r;
        on_ticks = on_len(on_code);
        per_ticks = per_len(per_code);
        running = (on_code != `HSST_ON_OFF) && (on_code != `HSST_ON_HIGH)
                  && (on_code != `HSST_CODE_RSV) && (per_code != `HSST_CODE_RSV);
        st_nxt.tick = 1'b0;
        if (st_r.div == 9'(`HSST_TICK_CYC - 1))
        begin
            st_nxt.div = 9'h000;
            st_nxt.tick = 1'b1;
        end
        else
        begin
            st_nxt.div = st_r.div + 9'h001;
        end
        // A new setting restarts the period, so a fresh pulse starts at once.
        if ((on_code != st_r.on_l) || (per_code != st_r.per_l))
        begin
            st_nxt.on_l = on_code;
            st_nxt.per_l = per_code;
            st_nxt.cnt = 18'h00000;
        end
        else if (running && st_r.tick)
        begin
            if (st_r.cnt + 18'h00001 >= per_ticks)
                st_nxt.cnt = 18'h00000;
            else
                st_nxt.cnt = st_r.cnt + 18'h00001;
        end
        if (on_code == `HSST_ON_HIGH)
            st_nxt.out = 1'b1;
        else if (running)
            st_nxt.out = (st_r.cnt < on_ticks);
        else
            st_nxt.out = 1'b0;
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign pulse_out = st_r.out;

endmodule
`default_nettype wire

// File: hsst_top.sv
/*
 * High-side switch source selection, second cyclic timer registers and
 * supply fault shutdown policy, reached over a classic Wishbone slave.
 * Assumes the first timer and both duty generators are on clk_sys, and
 * that fault inputs are asynchronous pins.
 */
// Added by the designer: the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none
`include "hsst_consts.svh"

// Summary of operation
// - Pulse-length code zero stops the second timer and holds its switches low.
// - Pulse-length codes one to five give 0.1, 0.3, 1, 10, 20 ms.
// - Pulse-length code six stops the timer with switches high; seven reserved.
// - Repeat-interval codes zero to six give 10 ms up to 2 s.
// - Timer starts by itself once a running pulse length is written, assigned or not.
// - Restart with cyclic sensing and cleared selectors also clears the timer.
// - Reserved bits ignore writes and read zero.
// - Bit six low lets supply overvoltage shut all four switches down.
// - Bit five low lets supply undervoltage shut all four switches down.
// - Bit four high restores prior switch states after the supply fault clears.
// - Selector codes pick off, on, either timer or either duty generator.
// - Low pair register holds switches one and two, high pair three and four.
// - Overcurrent or overtemperature clears that switch's selector.
// - Soft reset zeroes all; restart keeps fault bits 6:4 only.
module hsst_top
#(
    parameter int ADR_W = 10
)
(
    input  wire logic             clk_sys,
    input  wire logic             nrst,
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic      [31:0]      wb_dat_o,
    output logic                  wb_ack_o,
    input  wire logic             first_cyclic_timer,
    input  wire logic             first_duty_generator,
    input  wire logic             second_duty_generator,
    input  wire logic             cyclic_sense_on,
    input  wire logic             restart_state,
    input  wire logic             soft_reset_req,
    input  wire logic             restart_req,
    input  wire logic             supply_ov_in,
    input  wire logic             supply_uv_in,
    input  wire logic [3:0]       overcurrent_in,
    input  wire logic [3:0]       overtemp_in,
    output logic      [3:0]       assigned_switch_output
);

    ////////////////////////////////////////////////////////////////////////////

    logic rst_meta_r;
    logic rst_n;

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            rst_meta_r <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_n <= rst_meta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    hsst_pkg::hsst_state_type st_r;
    hsst_pkg::hsst_state_type st_nxt;

    logic       second_cyclic_timer;
    logic       wb_req;
    logic [7:0] wb_idx;
    logic       supply_shut;
    logic [3:0] sw_fault;

    function automatic logic [2:0] sel_of(input logic [7:0] lo,
                                          input logic [7:0] hi,
                                          input int         i);
        logic [7:0] r;
        r = (i < 2) ? lo : hi;
        if ((i % 2) == 0)
            sel_of = r[`HSST_LO_LSB +: 3];
        else
            sel_of = r[`HSST_HI_LSB +: 3];
    endfunction

    function automatic logic drive_of(input logic [2:0] code,
                                      input logic       ta,
                                      input logic       tb,
                                      input logic       da,
                                      input logic       db);
        case (code)
            `HSST_SEL_ON: drive_of = 1'b1;
            `HSST_SEL_TA: drive_of = ta;
            `HSST_SEL_TB: drive_of = tb;
            `HSST_SEL_DA: drive_of = da;
            `HSST_SEL_DB: drive_of = db;
            default:      drive_of = 1'b0;
        endcase
    endfunction

    hsst_cyc_timer u_timer_b
    (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .on_code   (st_r.tmr[`HSST_HI_LSB +: 3]),
        .per_code  (st_r.tmr[`HSST_LO_LSB +: 3]),
        .pulse_out (second_cyclic_timer)
    );

    ////////////////////////////////////////////////////////////////////////////

    assign wb_req = wb_cyc_i && wb_stb_i;
    assign wb_idx = wb_adr_i[9:2];
    assign supply_shut = (st_r.flt[`HSST_FLT_OV] && !st_r.sup[`HSST_BIT_OV_DIS])
                      || (st_r.flt[`HSST_FLT_UV] && !st_r.sup[`HSST_BIT_UV_DIS]);
    assign sw_fault = st_r.flt[`HSST_FLT_OC_LSB +: 4] | st_r.flt[`HSST_FLT_OT_LSB +: 4];

    always_comb
    begin
        logic [7:0] wdat;
        logic       clr_all;
        wdat = wb_dat_i[7:0];
        clr_all = 1'b0;
        st_nxt = st_r;

        // Pin faults: the first stage feeds only the second.
        st_nxt.s1 = {supply_ov_in, supply_uv_in, overtemp_in, overcurrent_in};
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        if (st_r.s2 == st_r.s3)
            st_nxt.flt = st_r.s3;

        // Answer one cycle after the request; ack lasts one cycle.
        st_nxt.ack = wb_req && !st_r.ack;
        st_nxt.rdat = `HSST_RST_VAL;
        if (wb_req && !st_r.ack && !wb_we_i)
        begin
            case (wb_idx)
                `HSST_IDX_TMR:  st_nxt.rdat = st_r.tmr;
                `HSST_IDX_SUP:  st_nxt.rdat = st_r.sup;
                `HSST_IDX_SWLO: st_nxt.rdat = st_r.sw_lo;
                `HSST_IDX_SWHI: st_nxt.rdat = st_r.sw_hi;
                default:        st_nxt.rdat = `HSST_RST_VAL;
            endcase
        end

        // A write lands on the edge where the master samples ack.
        if (wb_req && st_r.ack && wb_we_i && wb_sel_i[0])
        begin
            case (wb_idx)
                `HSST_IDX_TMR:  st_nxt.tmr = wdat & `HSST_TMR_MASK;
                `HSST_IDX_SUP:  st_nxt.sup = wdat & `HSST_SUP_MASK;
                `HSST_IDX_SWLO: st_nxt.sw_lo = wdat & `HSST_SW_MASK;
                `HSST_IDX_SWHI: st_nxt.sw_hi = wdat & `HSST_SW_MASK;
                default:        st_nxt.tmr = st_nxt.tmr;
            endcase
        end

        // Hardware clears override a software write in the same cycle, since
        // a faulted switch must never be re-armed by a racing write.
        if (sw_fault[0])
            st_nxt.sw_lo[`HSST_LO_LSB +: 3] = `HSST_SEL_OFF;
        if (sw_fault[1])
            st_nxt.sw_lo[`HSST_HI_LSB +: 3] = `HSST_SEL_OFF;
        if (sw_fault[2])
            st_nxt.sw_hi[`HSST_LO_LSB +: 3] = `HSST_SEL_OFF;
        if (sw_fault[3])
            st_nxt.sw_hi[`HSST_HI_LSB +: 3] = `HSST_SEL_OFF;

        // Without recovery the selectors are dropped, so the switches stay off.
        if (supply_shut && !st_r.sup[`HSST_BIT_REC])
            clr_all = 1'b1;
        if (clr_all)
        begin
            st_nxt.sw_lo = `HSST_RST_VAL;
            st_nxt.sw_hi = `HSST_RST_VAL;
        end

        if (restart_state && cyclic_sense_on
            && (st_r.sw_lo == `HSST_RST_VAL) && (st_r.sw_hi == `HSST_RST_VAL))
            st_nxt.tmr = `HSST_RST_VAL;

        if (soft_reset_req)
        begin
            st_nxt.tmr = `HSST_RST_VAL;
            st_nxt.sup = `HSST_RST_VAL;
            st_nxt.sw_lo = `HSST_RST_VAL;
            st_nxt.sw_hi = `HSST_RST_VAL;
        end
        else if (restart_req)
        begin
            st_nxt.tmr = `HSST_RST_VAL;
            st_nxt.sup = st_r.sup & `HSST_SUP_MASK;
            st_nxt.sw_lo = `HSST_RST_VAL;
            st_nxt.sw_hi = `HSST_RST_VAL;
        end

        // Outputs follow the current selectors; a supply shutdown masks them
        // all, and the selectors are kept for recovery only while bit four is high.
        for (int i = 0; i < 4; i++)
        begin
            st_nxt.out[i] = !supply_shut && !sw_fault[i]
                && drive_of(sel_of(st_r.sw_lo, st_r.sw_hi, i), first_cyclic_timer,
                            second_cyclic_timer, first_duty_generator,
                            second_duty_generator);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign wb_dat_o = {24'h000000, st_r.rdat};
    assign wb_ack_o = st_r.ack;
    assign assigned_switch_output = st_r.out;

    ////////////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    a_timer_off_low: assert property (
        $past(st_r.tmr[6:4]) == `HSST_ON_OFF && $past(st_r.tmr[6:4], 2) == `HSST_ON_OFF
        |-> !second_cyclic_timer)
        else $error("Second timer pulses with pulse length off.");

    a_timer_hold_high: assert property (
        $past(st_r.tmr[6:4]) == `HSST_ON_HIGH |-> second_cyclic_timer)
        else $error("Second timer not high with hold-high code.");

    a_short_pulse: assert property (
        $rose(second_cyclic_timer) && st_r.tmr == 8'h10 && $past(st_r.tmr) == 8'h10
        |-> second_cyclic_timer [*8])
        else $error("Shortest pulse ended too early.");

    a_reserved_zero: assert property (
        (st_r.tmr & ~`HSST_TMR_MASK) == 8'h00 && (st_r.sup & ~`HSST_SUP_MASK) == 8'h00
        && (st_r.sw_lo & ~`HSST_SW_MASK) == 8'h00 && (st_r.sw_hi & ~`HSST_SW_MASK) == 8'h00)
        else $error("Reserved register bit set.");

    a_ov_shutdown: assert property (
        st_r.flt[`HSST_FLT_OV] && !st_r.sup[`HSST_BIT_OV_DIS]
        |=> assigned_switch_output == 4'h0)
        else $error("Switch on during enabled overvoltage shutdown.");

    a_uv_shutdown: assert property (
        st_r.flt[`HSST_FLT_UV] && !st_r.sup[`HSST_BIT_UV_DIS]
        |=> assigned_switch_output == 4'h0)
        else $error("Switch on during enabled undervoltage shutdown.");

    a_no_recovery: assert property (
        supply_shut && !st_r.sup[`HSST_BIT_REC] && !soft_reset_req
        |=> st_r.sw_lo == 8'h00 && st_r.sw_hi == 8'h00)
        else $error("Selectors kept without recovery.");

    a_fault_clears: assert property (
        sw_fault[0] |=> st_r.sw_lo[2:0] == `HSST_SEL_OFF && !assigned_switch_output[0])
        else $error("Faulted switch one not cleared.");

    a_switch_on: assert property (
        $past(st_r.sw_lo[2:0]) == `HSST_SEL_ON && !$past(supply_shut) && !$past(sw_fault[0])
        |-> assigned_switch_output[0])
        else $error("Switch one not on with on selector.");

    a_restart_keep: assert property (
        restart_req && !soft_reset_req
        |=> st_r.sup == ($past(st_r.sup) & `HSST_SUP_MASK) && st_r.tmr == 8'h00)
        else $error("Restart did not keep fault bits.");

    a_restart_clear: assert property (
        restart_state && cyclic_sense_on && st_r.sw_lo == 8'h00 && st_r.sw_hi == 8'h00
        |=> st_r.tmr == 8'h00)
        else $error("Timer settings kept after restart clear.");

    a_ack_once: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("Acknowledge longer than one cycle.");

    a_ack_latency: assert property (
        wb_req && !wb_ack_o |=> wb_ack_o)
        else $error("Acknowledge not one cycle after request.");

    a_read_idle_zero: assert property (
        !wb_ack_o |-> wb_dat_o == 32'h00000000)
        else $error("Read data not zero outside acknowledge.");

    a_reserved_code_low: assert property (
        $past(st_r.tmr[`HSST_HI_LSB +: 3]) == `HSST_CODE_RSV |-> !second_cyclic_timer)
        else $error("Second timer high with reserved code.");

    a_fault_clears_two: assert property (
        sw_fault[1]
        |=> st_r.sw_lo[`HSST_HI_LSB +: 3] == `HSST_SEL_OFF && !assigned_switch_output[1])
        else $error("Faulted switch two not cleared.");

    a_fault_clears_three: assert property (
        sw_fault[2]
        |=> st_r.sw_hi[`HSST_LO_LSB +: 3] == `HSST_SEL_OFF && !assigned_switch_output[2])
        else $error("Faulted switch three not cleared.");

    a_fault_clears_four: assert property (
        sw_fault[3]
        |=> st_r.sw_hi[`HSST_HI_LSB +: 3] == `HSST_SEL_OFF && !assigned_switch_output[3])
        else $error("Faulted switch four not cleared.");

    a_soft_reset_zero: assert property (
        soft_reset_req
        |=> st_r.tmr == 8'h00 && st_r.sup == 8'h00 && st_r.sw_lo == 8'h00 && st_r.sw_hi == 8'h00)
        else $error("Registers not cleared by soft reset.");

    a_switch_off: assert property (
        $past(st_r.sw_lo[2:0]) == `HSST_SEL_OFF |-> !assigned_switch_output[0])
        else $error("Switch one on with off selector.");

    a_switch_timer_b: assert property (
        $past(st_r.sw_lo[2:0]) == `HSST_SEL_TB && !$past(supply_shut) && !$past(sw_fault[0])
        |-> assigned_switch_output[0] == $past(second_cyclic_timer))
        else $error("Switch one does not follow the second timer.");

    a_switch_four_on: assert property (
        $past(st_r.sw_hi[`HSST_HI_LSB +: 3]) == `HSST_SEL_ON && !$past(supply_shut)
        && !$past(sw_fault[3]) |-> assigned_switch_output[3])
        else $error("Switch four not on with on selector.");

    c_timer_pulse: cover property ($rose(second_cyclic_timer));
    c_supply_shut: cover property ($rose(supply_shut));
    c_fault_clear: cover property ($rose(sw_fault[0]));
    c_bus_write:   cover property (wb_ack_o && wb_we_i);
    c_restart:     cover property (restart_req);

endmodule
`default_nettype wire

// File: hsst_top_test.sv
/*
 * Self-checking testbench for the switch timer control block: register access,
 * source selection, second timer pulse length, supply and switch faults, resets.
 * Assumes hsst_top answers every Wishbone request one cycle after taking it.
 */
`timescale 1ns/100ps
`default_nettype none
`include "hsst_consts.svh"

module hsst_top_test;
    logic        clk_sys;
    logic        nrst;
    logic        wb_cyc_i;
    logic        wb_stb_i;
    logic        wb_we_i;
    logic [9:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        ta;
    logic        da;
    logic        db;
    logic        cyc_sense;
    logic        rst_state;
    logic        soft_req;
    logic        rst_req;
    logic        ov;
    logic        uv;
    logic [3:0]  oc;
    logic [3:0]  ot;
    logic [3:0]  sw_out;
    logic [7:0]  q;
    int          n_fail;
    int          compares;

    hsst_top #(.ADR_W(10)) uut (
        .clk_sys(clk_sys), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .first_cyclic_timer(ta),
        .first_duty_generator(da), .second_duty_generator(db), .cyclic_sense_on(cyc_sense),
        .restart_state(rst_state), .soft_reset_req(soft_req), .restart_req(rst_req),
        .supply_ov_in(ov), .supply_uv_in(uv), .overcurrent_in(oc), .overtemp_in(ot),
        .assigned_switch_output(sw_out));

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    task automatic print_verdict;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
            n_fail++;
        end
    endtask

    // The request stands until ack is sampled high; a lost ack ends the wait.
    task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] d,
                      input logic [3:0] sel);
        int n;
        @(posedge clk_sys);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_sel_i <= sel;
        wb_dat_i <= {24'h000000, d};
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 16);
        q = wb_dat_o[7:0];
        if (n >= 16)
            chk("ack", 32'h0, 32'h1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        wb(1'b1, idx, d, 4'h1);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        wb(1'b0, idx, 8'h00, 4'hf);
        chk("register", {24'h0, q}, {24'h0, exp});
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    function automatic logic sel_out(input logic [2:0] c, input logic tb_on);
        case (c)
            `HSST_SEL_ON: return 1'b1;
            `HSST_SEL_TA: return ta;
            `HSST_SEL_TB: return tb_on;
            `HSST_SEL_DA: return da;
            `HSST_SEL_DB: return db;
            default:      return 1'b0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // The longest stretch is the two pulse measurements, about 20000 cycles.
    initial
    begin
        repeat (100000) @(posedge clk_sys);
        n_fail++;
        print_verdict();
    end

    initial
    begin
        logic [7:0] idx_l[4]  = '{`HSST_IDX_TMR, `HSST_IDX_SUP, `HSST_IDX_SWLO, `HSST_IDX_SWHI};
        logic [7:0] mask_l[4] = '{`HSST_TMR_MASK, `HSST_SUP_MASK, `HSST_SW_MASK, `HSST_SW_MASK};
        logic [7:0] f_sup[6]  = '{8'h00, 8'h10, 8'h40, 8'h00, 8'h20, 8'h10};
        logic       f_ov[6]   = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
        logic [1:0] f_dur[6]  = '{2'h0, 2'h0, 2'h3, 2'h0, 2'h3, 2'h0};
        logic [1:0] f_aft[6]  = '{2'h0, 2'h3, 2'h3, 2'h0, 2'h3, 2'h3};
        int         on_us[2]  = '{`HSST_ON_US_1, `HSST_ON_US_2};
        logic       e;
        int         cnt;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
        {ta, da, db, cyc_sense, rst_state, soft_req, rst_req, ov, uv, oc, ot} = '0;
        nrst = 1'b0;
        n_fail = 0;
        compares = 0;
        idle(16);
        nrst <= 1'b1;
        idle(3);
        for (int i = 0; i < 4; i++)
            rd(idx_l[i], 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            wr(idx_l[i], 8'hff);
            rd(idx_l[i], mask_l[i]);
        end
        wr(8'h11, 8'hff);
        rd(8'h11, 8'h00);
        wb(1'b1, `HSST_IDX_TMR, 8'h00, 4'he);
        rd(`HSST_IDX_TMR, `HSST_TMR_MASK);
        // Every selector code against every input pattern, timer held low then high.
        for (int t = 0; t < 2; t++)
        begin
            wr(`HSST_IDX_TMR, t ? {1'b0, `HSST_ON_HIGH, 4'h0} : 8'h00);
            for (int p = 0; p < 8; p++)
            begin
                {ta, da, db} <= p[2:0];
                for (int c = 0; c < 8; c++)
                begin
                    wr(`HSST_IDX_SWLO, {1'b0, `HSST_SEL_ON, 1'b0, c[2:0]});
                    wr(`HSST_IDX_SWHI, {1'b0, c[2:0], 4'h0});
                    idle(3);
                    e = sel_out(c[2:0], t[0]);
                    chk("outputs", {28'h0, sw_out}, {28'h0, e, 2'b01, e});
                end
            end
        end
        {ta, da, db} <= 3'b000;
        // The first tick may come early, so a pulse may be up to one tick short.
        wr(`HSST_IDX_SWLO, {5'h00, `HSST_SEL_TB});
        for (int i = 0; i < 2; i++)
        begin
            wr(`HSST_IDX_TMR, {1'b0, i[2:0] + 3'h1, 4'h0});
            cnt = 0;
            while (sw_out[0] !== 1'b1 && cnt < 2000)
            begin
                @(posedge clk_sys);
                cnt++;
            end
            cnt = 0;
            while (sw_out[0] === 1'b1 && cnt < 60000)
            begin
                @(posedge clk_sys);
                cnt++;
            end
            e = (cnt >= on_us[i] * 50 - `HSST_TICK_CYC - 3) && (cnt <= on_us[i] * 50 + 3);
            chk("pulse length", {31'h0, e}, 32'h1);
        end
        wr(`HSST_IDX_TMR, 8'h00);
        for (int i = 0; i < 6; i++)
        begin
            wr(`HSST_IDX_SUP, f_sup[i]);
            wr(`HSST_IDX_SWLO, 8'h11);
            if (f_ov[i])
                ov <= 1'b1;
            else
                uv <= 1'b1;
            idle(8);
            chk("supply fault", {30'h0, sw_out[1:0]}, {30'h0, f_dur[i]});
            ov <= 1'b0;
            uv <= 1'b0;
            idle(8);
            chk("recovery", {30'h0, sw_out[1:0]}, {30'h0, f_aft[i]});
            rd(`HSST_IDX_SWLO, (f_aft[i] != 2'h0) ? 8'h11 : 8'h00);
        end
        wr(`HSST_IDX_SUP, 8'h00);
        wr(`HSST_IDX_SWHI, 8'h11);
        oc <= 4'h4;
        idle(8);
        chk("overcurrent", {31'h0, sw_out[2]}, 32'h0);
        oc <= 4'h0;
        rd(`HSST_IDX_SWHI, 8'h10);
        ot <= 4'h8;
        idle(8);
        chk("overtemp", {31'h0, sw_out[3]}, 32'h0);
        ot <= 4'h0;
        rd(`HSST_IDX_SWHI, 8'h00);
        wr(`HSST_IDX_SUP, 8'hff);
        wr(`HSST_IDX_TMR, 8'h12);
        wr(`HSST_IDX_SWLO, 8'h11);
        rst_req <= 1'b1;
        idle(1);
        rst_req <= 1'b0;
        rd(`HSST_IDX_SUP, 8'h70);
        rd(`HSST_IDX_TMR, 8'h00);
        rd(`HSST_IDX_SWLO, 8'h00);
        soft_req <= 1'b1;
        idle(1);
        soft_req <= 1'b0;
        rd(`HSST_IDX_SUP, 8'h00);
        rst_state <= 1'b1;
        cyc_sense <= 1'b1;
        wr(`HSST_IDX_TMR, 8'h12);
        rd(`HSST_IDX_TMR, 8'h00);
        wr(`HSST_IDX_SWLO, 8'h03);
        wr(`HSST_IDX_TMR, 8'h12);
        rd(`HSST_IDX_TMR, 8'h12);
        wr(`HSST_IDX_SWLO, 8'h00);
        idle(3);
        rd(`HSST_IDX_TMR, 8'h00);
        print_verdict();
    end
endmodule
`default_nettype wire
